/* File: common/tmr_defines.svh */
// Constants of the three-channel down-counter timer: bus addresses,
// control word field positions, format and waveform codes, reset values.
// Assumes inclusion by bare name from design and test files.
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// Address of the control word; addresses 0 to 2 reach the counters.
`define TMR_ADDR_CTRL    2'h3
`define TMR_SEL_ILLEGAL  2'h3

// Control word field positions.
`define TMR_CW_SEL_MSB   7
`define TMR_CW_SEL_LSB   6
`define TMR_CW_RLF_MSB   5
`define TMR_CW_RLF_LSB   4
`define TMR_CW_WSEL_MSB  3
`define TMR_CW_WSEL_LSB  1
`define TMR_CW_BCD       0

// Read/load format codes.
`define TMR_RLF_LATCH    2'h0
`define TMR_RLF_LSB      2'h1
`define TMR_RLF_MSB      2'h2
`define TMR_RLF_WORD     2'h3

// Waveform select codes after folding the don't-care top bit.
`define TMR_MODE_TC      3'h0
`define TMR_MODE_ONESHOT 3'h1
`define TMR_MODE_RATE    3'h2
`define TMR_MODE_SQUARE  3'h3
`define TMR_MODE_SWSTB   3'h4
`define TMR_MODE_HWSTB   3'h5

// Reset values.
`define TMR_CNT_RST      16'h0000
`define TMR_OUT_RST      1'b1
`define TMR_BYTE_RST     8'h00

`endif

/* File: common/tmr_pkg.sv */
// Types shared by the timer design files.
// Assumes tmr_defines.svh for the numeric constants.
`default_nettype none
package tmr_pkg;

   // One host bus cycle, sampled synchronously with the system clock.
   typedef struct packed {
      logic       cs;
      logic       rd;
      logic       wr;
      logic [1:0] addr;
      logic [7:0] wdata;
   } tmr_bus_s;

   // Sixteen-bit count value.
   typedef logic [15:0] tmr_cnt_t;

   // Counting phase of one channel.
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_LOAD,
      PH_RUN
   } tmr_phase_e;

endpackage
`default_nettype wire

/* File: logic/tmr_edge.sv */
// Registered level and rising-edge detector for a group of inputs.
// Assumes the inputs are synchronous to i_clk_sys.
`timescale 1ns/1ps
`default_nettype none
module tmr_edge #(
   parameter int W = 3
) (
   input  wire logic         i_clk_sys,
   input  wire logic         i_sys_rst,
   input  wire logic [W-1:0] i_sig,
   output logic      [W-1:0] o_level,
   output logic      [W-1:0] o_rise
);

   // Level and edge come from the same stage so they stay aligned.
   // The level follows the pin during reset, so a pin already high at release
   // is not mistaken for a rising edge.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_level <= i_sig;
         o_rise  <= '0;
      end else begin
         o_level <= i_sig;
         o_rise  <= i_sig & ~o_level;
      end
   end

endmodule
`default_nettype wire

/* File: logic/tmr_step.sv */
// Down-step arithmetic for one counter: one and two steps, binary or BCD.
// Purely combinational; assumes a 16-bit count.
`timescale 1ns/1ps
`default_nettype none
module tmr_step
   import tmr_pkg::*;
(
   input  wire tmr_cnt_t i_val,
   input  wire logic     i_bcd,
   output tmr_cnt_t      o_dec1,
   output tmr_cnt_t      o_dec2
);

   // Subtract one; in BCD each decade borrows at zero and wraps 0000 to 9999.
   function automatic tmr_cnt_t dec_one(input tmr_cnt_t v, input logic bcd);
      tmr_cnt_t r;
      logic     borrow;
      r      = v;
      borrow = 1'b1;
      if (bcd) begin
         for (int d = 0; d < 4; d++) begin
            if (borrow) begin
               if (v[d*4 +: 4] == 4'h0) begin
                  r[d*4 +: 4] = 4'h9;
               end else begin
                  r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
                  borrow      = 1'b0;
               end
            end
         end
      end else begin
         r = v - 16'h0001;
      end
      return r;
   endfunction

   // Square-wave counting steps by two, done as two single steps.
   always_comb begin
      o_dec1 = dec_one(i_val, i_bcd);
      o_dec2 = dec_one(o_dec1, i_bcd);
   end

endmodule
`default_nettype wire

/* File: logic/tmr_core.sv */
// Three-channel 16-bit down-counter with a byte-wide host port.
// Assumes host bus strobes, count clocks and gates are synchronous to
// i_clk_sys; each strobe is high for one cycle per bus access.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defines.svh"
module tmr_core
   import tmr_pkg::*;
#(
   parameter int N_CH = 3
) (
   input  wire logic            i_clk_sys,
   input  wire logic            i_sys_rst,
   input  wire tmr_bus_s        i_bus,
   input  wire logic [N_CH-1:0] i_cnt_clk,
   input  wire logic [N_CH-1:0] i_gate,
   output logic      [7:0]      o_rdata,
   output logic                 o_rd_valid,
   output logic      [N_CH-1:0] o_out
);

   logic [N_CH-1:0] tick;
   logic [N_CH-1:0] gate_lvl;
   logic [N_CH-1:0] gate_rise;
   logic [7:0]      rd_byte [N_CH];

   // Count clocks and gates are seen one cycle late, edges and levels alike.
   tmr_edge #(
      .W (N_CH)
   ) u_clk_edge (
      .i_clk_sys (i_clk_sys),
      .i_sys_rst (i_sys_rst),
      .i_sig     (i_cnt_clk),
      .o_level   (),
      .o_rise    (tick)
   );

   tmr_edge #(
      .W (N_CH)
   ) u_gate_edge (
      .i_clk_sys (i_clk_sys),
      .i_sys_rst (i_sys_rst),
      .i_sig     (i_gate),
      .o_level   (gate_lvl),
      .o_rise    (gate_rise)
   );

   // Control word fields, decoded once for all channels.
   logic       cw_wr;
   logic       bus_wr;
   logic       bus_rd;
   logic [1:0] cw_sel;
   logic [1:0] cw_rlf;
   logic [2:0] cw_mode;

   always_comb begin
      bus_wr  = i_bus.cs & i_bus.wr;
      bus_rd  = i_bus.cs & i_bus.rd;
      cw_wr   = bus_wr & (i_bus.addr == `TMR_ADDR_CTRL);
      cw_sel  = i_bus.wdata[`TMR_CW_SEL_MSB:`TMR_CW_SEL_LSB];
      cw_rlf  = i_bus.wdata[`TMR_CW_RLF_MSB:`TMR_CW_RLF_LSB];
      // Codes x10 and x11 both mean rate and square wave.
      cw_mode = i_bus.wdata[`TMR_CW_WSEL_MSB:`TMR_CW_WSEL_LSB];
      if (cw_mode[1]) begin
         cw_mode = {1'b0, cw_mode[1:0]};
      end
   end

   for (genvar ch = 0; ch < N_CH; ch++) begin : g_ch
      logic [2:0] mode_r;
      logic [1:0] rlf_r;
      logic       bcd_r;
      tmr_cnt_t   cr_r;
      logic [7:0] lsb_hold_r;
      logic       wr_msb_r;
      tmr_cnt_t   ce_r;
      tmr_phase_e ph_r;
      logic       out_r;
      logic       trig_r;
      logic       fired_r;
      logic       extra_r;
      tmr_cnt_t   ol_r;
      logic       latched_r;
      logic       rd_msb_r;
      tmr_cnt_t   dec1;
      tmr_cnt_t   dec2;
      tmr_cnt_t   half_ld;
      tmr_cnt_t   src;
      logic       cw_set;
      logic       latch_cmd;
      logic       dw;
      logic       cnt_done;
      logic       lsb_stop;
      logic       rd_hit;
      logic       gate_ok;

      tmr_step u_step (
         .i_val  (ce_r),
         .i_bcd  (bcd_r),
         .o_dec1 (dec1),
         .o_dec2 (dec2)
      );

      // Per-channel access decode; counter select 11 matches no channel.
      always_comb begin
         cw_set    = cw_wr & (cw_sel == 2'(ch)) & (cw_rlf != `TMR_RLF_LATCH);
         latch_cmd = cw_wr & (cw_sel == 2'(ch)) & (cw_rlf == `TMR_RLF_LATCH);
         dw        = bus_wr & (i_bus.addr == 2'(ch));
         rd_hit    = bus_rd & (i_bus.addr == 2'(ch));
         // A word load is complete only with its high byte.
         cnt_done  = dw & ((rlf_r != `TMR_RLF_WORD) | wr_msb_r);
         lsb_stop  = dw & (rlf_r == `TMR_RLF_WORD) & ~wr_msb_r
                     & (mode_r == `TMR_MODE_TC);
         // Square wave counts an even value; odd counts add a tick high.
         half_ld   = {cr_r[15:1], 1'b0};
         // Gate level matters only outside the edge-triggered modes.
         gate_ok   = gate_lvl[ch] | (mode_r == `TMR_MODE_ONESHOT)
                     | (mode_r == `TMR_MODE_HWSTB);
         src       = latched_r ? ol_r : ce_r;
      end

      // Programming: control word fields and the count register.
      always_ff @(posedge i_clk_sys) begin
         if (i_sys_rst) begin
            mode_r     <= `TMR_MODE_TC;
            rlf_r      <= `TMR_RLF_WORD;
            bcd_r      <= 1'b0;
            cr_r       <= `TMR_CNT_RST;
            lsb_hold_r <= `TMR_BYTE_RST;
            wr_msb_r   <= 1'b0;
         end else if (cw_set) begin
            mode_r   <= cw_mode;
            rlf_r    <= cw_rlf;
            bcd_r    <= i_bus.wdata[`TMR_CW_BCD];
            wr_msb_r <= 1'b0;
         end else if (dw) begin
            case (rlf_r)
               `TMR_RLF_LSB: cr_r <= {8'h00, i_bus.wdata};
               `TMR_RLF_MSB: cr_r <= {i_bus.wdata, 8'h00};
               default: begin
                  // The low byte waits so a running count never sees half a value.
                  if (wr_msb_r) begin
                     cr_r <= {i_bus.wdata, lsb_hold_r};
                  end else begin
                     lsb_hold_r <= i_bus.wdata;
                  end
                  wr_msb_r <= ~wr_msb_r;
               end
            endcase
         end
      end

      // Gate rising edges wait for the next count clock; a new edge wins.
      always_ff @(posedge i_clk_sys) begin
         if (i_sys_rst | cw_set) begin
            trig_r <= 1'b0;
         end else begin
            trig_r <= (trig_r & ~tick[ch]) | gate_rise[ch];
         end
      end

      // Counting element, phase and output waveform.
      always_ff @(posedge i_clk_sys) begin
         if (i_sys_rst) begin
            ph_r    <= PH_IDLE;
            ce_r    <= `TMR_CNT_RST;
            out_r   <= `TMR_OUT_RST;
            fired_r <= 1'b0;
            extra_r <= 1'b0;
         end else if (cw_set) begin
            // Programming clears the count; only terminal-count mode starts low.
            ph_r    <= PH_IDLE;
            ce_r    <= `TMR_CNT_RST;
            out_r   <= (cw_mode != `TMR_MODE_TC);
            fired_r <= 1'b0;
            extra_r <= 1'b0;
         end else if (lsb_stop) begin
            ph_r <= PH_IDLE;
         end else if (cnt_done) begin
            case (mode_r)
               `TMR_MODE_TC: begin
                  out_r <= 1'b0;
                  ph_r  <= PH_LOAD;
               end
               `TMR_MODE_SWSTB: begin
                  out_r   <= 1'b1;
                  fired_r <= 1'b0;
                  ph_r    <= PH_LOAD;
               end
               `TMR_MODE_RATE, `TMR_MODE_SQUARE: begin
                  // A running count picks up the new value at its next reload.
                  if (ph_r == PH_IDLE) begin
                     ph_r <= PH_LOAD;
                  end
               end
               default: begin
                  // One-shot and hardware strobe wait for a gate trigger.
               end
            endcase
         end else if (tick[ch]) begin
            case (ph_r)
               PH_LOAD: begin
                  if (gate_lvl[ch] | ((mode_r != `TMR_MODE_RATE)
                                      & (mode_r != `TMR_MODE_SQUARE))) begin
                     ce_r    <= (mode_r == `TMR_MODE_SQUARE) ? half_ld : cr_r;
                     ph_r    <= PH_RUN;
                     extra_r <= 1'b0;
                  end
               end
               PH_IDLE: begin
                  if (trig_r & ((mode_r == `TMR_MODE_ONESHOT)
                                | (mode_r == `TMR_MODE_HWSTB))) begin
                     ce_r    <= cr_r;
                     ph_r    <= PH_RUN;
                     fired_r <= 1'b0;
                     if (mode_r == `TMR_MODE_ONESHOT) begin
                        out_r <= 1'b0;
                     end
                  end
               end
               PH_RUN: begin
                  if (trig_r & (mode_r != `TMR_MODE_TC)) begin
                     // Edge retrigger or gate-return restart from the set value.
                     ce_r    <= (mode_r == `TMR_MODE_SQUARE) ? half_ld : cr_r;
                     fired_r <= 1'b0;
                     extra_r <= 1'b0;
                     out_r   <= (mode_r != `TMR_MODE_ONESHOT);
                  end else if (gate_ok) begin
                     case (mode_r)
                        `TMR_MODE_TC, `TMR_MODE_ONESHOT: begin
                           ce_r <= dec1;
                           if (ce_r == 16'h0001) begin
                              out_r <= 1'b1;
                           end
                        end
                        `TMR_MODE_RATE: begin
                           if (ce_r == 16'h0001) begin
                              ce_r  <= cr_r;
                              out_r <= 1'b1;
                           end else begin
                              ce_r <= dec1;
                              if (ce_r == 16'h0002) begin
                                 out_r <= 1'b0;
                              end
                           end
                        end
                        `TMR_MODE_SQUARE: begin
                           if (ce_r == 16'h0002) begin
                              if (out_r & cr_r[0] & ~extra_r) begin
                                 extra_r <= 1'b1;
                              end else begin
                                 out_r   <= ~out_r;
                                 ce_r    <= half_ld;
                                 extra_r <= 1'b0;
                              end
                           end else begin
                              ce_r <= dec2;
                           end
                        end
                        default: begin
                           // Strobe modes: low one tick as the count reaches zero,
                           // one tick after where the rate generator goes low.
                           ce_r <= dec1;
                           if (!out_r) begin
                              out_r <= 1'b1;
                           end else if ((ce_r == 16'h0001) & ~fired_r) begin
                              out_r   <= 1'b0;
                              fired_r <= 1'b1;
                           end
                        end
                     endcase
                  end
               end
               default: begin
                  ph_r <= PH_IDLE;
               end
            endcase
         end
         // A low gate forces the periodic outputs high at once.
         if (!cw_set && !i_sys_rst && !gate_lvl[ch]
             && ((mode_r == `TMR_MODE_RATE) || (mode_r == `TMR_MODE_SQUARE))) begin
            out_r <= 1'b1;
         end
      end

      // Read-back: latch on command, then steer bytes by the read format.
      always_ff @(posedge i_clk_sys) begin
         if (i_sys_rst | cw_set) begin
            ol_r      <= `TMR_CNT_RST;
            latched_r <= 1'b0;
            rd_msb_r  <= 1'b0;
         end else if (latch_cmd) begin
            // A second latch before the first is read keeps the older value.
            if (!latched_r) begin
               ol_r      <= ce_r;
               latched_r <= 1'b1;
            end
            rd_msb_r <= 1'b0;
         end else if (rd_hit) begin
            if (rlf_r == `TMR_RLF_WORD) begin
               rd_msb_r <= ~rd_msb_r;
            end
            if ((rlf_r != `TMR_RLF_WORD) | rd_msb_r) begin
               latched_r <= 1'b0;
            end
         end
      end

      // Byte offered to the host; direct reads are only exact when frozen.
      always_comb begin
         case (rlf_r)
            `TMR_RLF_MSB:  rd_byte[ch] = src[15:8];
            `TMR_RLF_WORD: rd_byte[ch] = rd_msb_r ? src[15:8] : src[7:0];
            default:       rd_byte[ch] = src[7:0];
         endcase
      end

      assign o_out[ch] = out_r;
   end

   // Host read data, registered; the control word address reads as zero.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_rdata    <= `TMR_BYTE_RST;
         o_rd_valid <= 1'b0;
      end else begin
         o_rd_valid <= bus_rd;
         if (bus_rd) begin
            if (i_bus.addr < 2'(N_CH)) begin
               o_rdata <= rd_byte[i_bus.addr];
            end else begin
               o_rdata <= `TMR_BYTE_RST;
            end
         end
      end
   end

endmodule
`default_nettype wire

/* File: test/tmr_properties.sv */
// Concurrent checks on the timer core ports, bound into every core.
// Assumes one clock domain and host strobes of one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defines.svh"
module tmr_properties
   import tmr_pkg::*;
#(
   parameter int N_CH = 3
) (
   input  wire logic            i_clk_sys,
   input  wire logic            i_sys_rst,
   input  wire tmr_bus_s        i_bus,
   input  wire logic [N_CH-1:0] i_cnt_clk,
   input  wire logic [N_CH-1:0] i_gate,
   input  wire logic [7:0]      o_rdata,
   input  wire logic            o_rd_valid,
   input  wire logic [N_CH-1:0] o_out
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   logic            cw;
   logic [1:0]      sel;
   logic [2:0]      code;
   logic [1:0]      cwd_r;
   logic [N_CH-1:0] prv_r;
   logic [3:0]      tk_r [N_CH];
   logic [3:0]      gl_r [N_CH];
   logic [2:0]      mode_r [N_CH];
   // Control word decode; codes x1x fold their top bit away.
   assign cw = i_bus.cs & i_bus.wr & (i_bus.addr == `TMR_ADDR_CTRL);
   assign sel = i_bus.wdata[7:6];
   assign code = i_bus.wdata[2] ? {1'b0, i_bus.wdata[2:1]} : i_bus.wdata[3:1];
   // Tick and gate history span four cycles, so an exact pipeline depth is not assumed.
   always_ff @(posedge i_clk_sys) begin
      prv_r <= i_cnt_clk;
      cwd_r <= {cwd_r[0], cw};
      for (int c = 0; c < N_CH; c++) begin
         tk_r[c] <= {tk_r[c][2:0], i_cnt_clk[c] & ~prv_r[c]};
         gl_r[c] <= {gl_r[c][2:0], ~i_gate[c]};
         if (i_sys_rst) begin
            mode_r[c] <= `TMR_MODE_TC;
         end else if (cw && sel == 2'(c) && i_bus.wdata[5:4] != `TMR_RLF_LATCH) begin
            mode_r[c] <= code;
         end
      end
   end
   sequence s_read;
      i_bus.cs && i_bus.rd && !i_bus.wr;
   endsequence
   sequence s_latch;
      cw && i_bus.wdata[5:4] == `TMR_RLF_LATCH;
   endsequence
   sequence s_set(logic [2:0] m);
      cw && sel != `TMR_SEL_ILLEGAL && i_bus.wdata[5:4] != `TMR_RLF_LATCH && code == m;
   endsequence
   // Read answers and control word effects on the outputs.
   a_read_answer: assert property (s_read |=> o_rd_valid)
      else $error("read strobe not answered next cycle");
   a_valid_cause: assert property (o_rd_valid |-> $past(i_bus.cs && i_bus.rd))
      else $error("read valid without a read strobe");
   a_strobe_high: assert property ((s_set(`TMR_MODE_SWSTB) or s_set(`TMR_MODE_HWSTB))
      |=> o_out[$past(sel)])
      else $error("strobe mode did not drive output high");
   a_rate_high: assert property ((s_set(`TMR_MODE_RATE) or s_set(`TMR_MODE_SQUARE))
      |=> o_out[$past(sel)])
      else $error("rate mode did not drive output high");
   a_tc_low: assert property (s_set(`TMR_MODE_TC) |=> !o_out[$past(sel)])
      else $error("terminal count mode did not drive output low");
   // Per channel relations between ticks, gates and the output.
   for (genvar c = 0; c < N_CH; c++) begin : g_ch
      a_latch_quiet: assert property (s_latch ##1 tk_r[c] == 4'h0 |-> $stable(o_out[c]))
         else $error("latch command disturbed an output");
      a_tick_moves: assert property (mode_r[c] inside {`TMR_MODE_TC, `TMR_MODE_ONESHOT,
         `TMR_MODE_SWSTB, `TMR_MODE_HWSTB} && $changed(o_out[c]) && cwd_r == 2'h0
         |-> tk_r[c] != 4'h0)
         else $error("output moved without a count tick");
      a_gate_hold_hi: assert property (mode_r[c] inside {`TMR_MODE_RATE, `TMR_MODE_SQUARE}
         && gl_r[c] == 4'hf |-> o_out[c])
         else $error("low gate did not hold output high");
   end
endmodule
bind tmr_core tmr_properties #(.N_CH(N_CH)) u_props (.i_clk_sys(i_clk_sys),
   .i_sys_rst(i_sys_rst), .i_bus(i_bus), .i_cnt_clk(i_cnt_clk), .i_gate(i_gate),
   .o_rdata(o_rdata), .o_rd_valid(o_rd_valid), .o_out(o_out));
`default_nettype wire

/* File: test/tmr_host_model.sv */
// Host processor model that drives the timer's byte-wide bus.
// Assumes the bench calls its tasks; each access holds its strobe one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defines.svh"
module tmr_host_model
   import tmr_pkg::*;
(
   input  wire logic i_clk_sys,
   output tmr_bus_s  o_bus
);
   tmr_bus_s last_r;
   initial o_bus = '0;
   // One access, changed just after an edge and released after the taking edge.
   // Released lines show the inverse of the last value, so stale data never passes.
   task automatic access(input logic w, input logic [1:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      #1;
      o_bus = {1'b1, ~w, w, a, d};
      last_r = o_bus;
      @(posedge i_clk_sys);
      #1;
      o_bus = {3'h0, ~last_r.addr, ~last_r.wdata};
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      access(1'b1, a, d);
   endtask
   task automatic rd(input logic [1:0] a);
      access(1'b0, a, ~last_r.wdata);
   endtask
   // Always the two-byte format, waveform code in bits three to one.
   task automatic set_mode(input logic [1:0] ch, input logic [2:0] m);
      wr(`TMR_ADDR_CTRL, {ch, `TMR_RLF_WORD, m, 1'b0});
   endtask
   // Low byte first; the count takes effect with the high byte.
   task automatic load(input logic [1:0] ch, input logic [15:0] v);
      wr(ch, v[7:0]);
      wr(ch, v[15:8]);
   endtask
   // Running counters are read only through the latch, never directly.
   task automatic latch(input logic [1:0] ch);
      wr(`TMR_ADDR_CTRL, {ch, `TMR_RLF_LATCH, 4'h0});
   endtask
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the timer core: strobe modes, gate roles, latched reads.
// Assumes the host model owns the bus; the bench drives count clocks and gates.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defines.svh"
module testbench
   import tmr_pkg::*;
();
   logic       i_clk_sys = 1'b0;
   logic       i_sys_rst = 1'b1;
   tmr_bus_s   bus;
   logic [2:0] cnt_clk = 3'h0;
   logic [2:0] gate = 3'h0;
   logic [7:0] rdata;
   logic       rd_valid;
   logic [2:0] out;
   logic       smp = 1'b0;
   int         fails = 0;
   int         tests_run = 0;
   int         lows;
   int         n;
   logic [7:0] rd_q[$];
   logic [2:0] out_q[$];
   logic [2:0] pat_a[6] = '{3'h7, 3'h7, 3'h3, 3'h6, 3'h7, 3'h3};
   // Free-running system clock, 10 ns period.
   always #5 i_clk_sys = ~i_clk_sys;
   tmr_host_model host (.i_clk_sys(i_clk_sys), .o_bus(bus));
   tmr_core #(.N_CH(3)) DUT (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_bus(bus),
      .i_cnt_clk(cnt_clk), .i_gate(gate), .o_rdata(rdata), .o_rd_valid(rd_valid), .o_out(out));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (fails == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // A count tick is two cycles high, then three low so the output has settled.
   task automatic tick(input logic [2:0] m);
      cnt_clk = m;
      repeat (2) @(posedge i_clk_sys);
      #1;
      cnt_clk = 3'h0;
      repeat (3) @(posedge i_clk_sys);
      #1;
   endtask
   // Counts the ticks after which one channel's output stood low.
   task automatic count_lows(input int ch, input int k);
      lows = 0;
      repeat (k) begin
         tick(3'h1 << ch);
         if (out[ch] === 1'b0) lows++;
      end
   endtask
   task automatic expo(input logic [2:0] v);
      out_q.push_back(v);
      smp = 1'b1;
      @(posedge i_clk_sys);
      #1;
      smp = 1'b0;
   endtask
   task automatic rdx(input logic [1:0] a, input logic [7:0] v);
      rd_q.push_back(v);
      host.rd(a);
   endtask
   task automatic setg(input int ch, input logic v);
      gate[ch] = v;
      repeat (3) @(posedge i_clk_sys);
      #1;
   endtask
   // Each result that appears is compared with the oldest note of its kind.
   always @(posedge i_clk_sys) begin
      if (rd_valid === 1'b1) begin
         check({8'h00, rdata}, {8'h00, rd_q.pop_front()});
      end
      if (smp) begin
         check({13'h0000, out}, {13'h0000, out_q.pop_front()});
      end
   end
   // Watchdog: a hang counts as a mismatch.
   initial begin
      repeat (50000) @(posedge i_clk_sys);
      fails++;
      give_verdict();
   end
   // Main sequence.
   initial begin
      void'($urandom(32'hd3a06734));
      repeat (20) @(posedge i_clk_sys);
      #1;
      i_sys_rst = 1'b0;
      expo(3'h7);
      rdx(`TMR_ADDR_CTRL, 8'h00);
      // Software strobe beside a rate generator, same count, same ticks.
      setg(0, 1'b1);
      setg(2, 1'b1);
      host.set_mode(2'h0, `TMR_MODE_SWSTB);
      host.set_mode(2'h2, `TMR_MODE_RATE);
      expo(3'h7);
      host.load(2'h0, 16'h0003);
      host.load(2'h2, 16'h0003);
      foreach (pat_a[i]) begin
         tick(3'h5);
         expo(pat_a[i]);
      end
      setg(2, 1'b0);
      expo(3'h7);
      count_lows(2, 3);
      check(16'(lows), 16'h0000);
      // Software strobe stopped by a low gate, restarted from the set count.
      host.set_mode(2'h0, `TMR_MODE_SWSTB);
      host.load(2'h0, 16'h0003);
      tick(3'h1);
      tick(3'h1);
      setg(0, 1'b0);
      count_lows(0, 2);
      check(16'(lows), 16'h0000);
      setg(0, 1'b1);
      count_lows(0, 2);
      check(16'(lows), 16'h0000);
      count_lows(0, 3);
      check(16'(lows), 16'h0001);
      // Hardware strobe: a high level starts nothing, each rise retriggers.
      setg(1, 1'b1);
      host.set_mode(2'h1, `TMR_MODE_HWSTB);
      host.load(2'h1, 16'h0003);
      count_lows(1, 4);
      check(16'(lows), 16'h0000);
      setg(1, 1'b0);
      setg(1, 1'b1);
      count_lows(1, 2);
      check(16'(lows), 16'h0000);
      setg(1, 1'b0);
      setg(1, 1'b1);
      count_lows(1, 2);
      check(16'(lows), 16'h0000);
      count_lows(1, 3);
      check(16'(lows), 16'h0001);
      // One-shot: low from the tick after the trigger until terminal count.
      host.set_mode(2'h1, `TMR_MODE_ONESHOT);
      host.load(2'h1, 16'h0002);
      setg(1, 1'b0);
      setg(1, 1'b1);
      count_lows(1, 3);
      check(16'(lows), 16'h0002);
      // Latched read of a running terminal count channel with a random count.
      n = 2 + ($urandom % 8);
      setg(2, 1'b1);
      host.set_mode(2'h2, `TMR_MODE_TC);
      host.load(2'h2, 16'(16'h0100 + n));
      repeat (3) tick(3'h4);
      host.latch(2'h2);
      repeat (2) tick(3'h4);
      rdx(2'h2, 8'(n - 2));
      rdx(2'h2, 8'h01);
      count_lows(2, 251 + n);
      check(16'(lows), 16'(251 + n));
      count_lows(2, 1);
      check(16'(lows), 16'h0000);
      // Cascade: the inverted rate output clocks the terminal count channel, once per low pulse.
      host.set_mode(2'h0, `TMR_MODE_RATE);
      host.set_mode(2'h2, `TMR_MODE_TC);
      host.load(2'h0, 16'h0002);
      host.load(2'h2, 16'h0002);
      repeat (6) tick({~out[0], 2'h1});
      expo(3'h2);
      tick({~out[0], 2'h1});
      expo(3'h7);
      // Square wave of four: two ticks high, then two low, stepping by two.
      host.set_mode(2'h0, `TMR_MODE_SQUARE);
      host.load(2'h0, 16'h0004);
      count_lows(0, 5);
      check(16'(lows), 16'h0002);
      check(16'(rd_q.size()), 16'h0000);
      give_verdict();
   end
endmodule
`default_nettype wire
